// File: shared/tev_pkg.sv
package tev_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int          ADDR_W         = 6;
  localparam int          DATA_W         = 32;
  localparam logic [5:0]  OFF_CTRL       = 6'h00;
  localparam logic [5:0]  OFF_STATUS     = 6'h20;
  localparam logic [5:0]  OFF_ENABLE     = 6'h24;
  localparam logic [5:0]  OFF_FLAG       = 6'h28;
  localparam logic [5:0]  OFF_PENDING    = 6'h2C;
  localparam logic [5:0]  OFF_MASK       = 6'h30;

  // ****************************************
  // event field layout
  // ****************************************
  localparam int          EV_W           = 7;
  localparam int          SRC_W          = 3;
  localparam int          BIT_GATE_RISE  = 0;
  localparam int          BIT_SYNC_RISE  = 1;
  localparam int          BIT_SEC_RISE   = 2;
  localparam int          BIT_GATE_FALL  = 4;
  localparam int          BIT_SYNC_FALL  = 5;
  localparam int          BIT_SEC_FALL   = 6;
  localparam int          FALL_BASE      = 4;
  localparam logic [6:0]  EV_VALID       = 7'h77;
  localparam logic [6:0]  EV_RESET       = 7'h00;
  localparam int          CTRL_W         = 8;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [31:0] READ_UNMAPPED  = 32'h0000_0000;

  typedef enum logic [1:0] {
    TEV_BUS_IDLE = 2'b00,
    TEV_BUS_ACK  = 2'b01
  } tev_bus_state_t;

endpackage : tev_pkg

// File: core/tev_edge_det.sv
`timescale 1ns/1ps
`default_nettype none

module tev_edge_det #(
  parameter int W = 3
) (
  input  wire logic         ref_clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] src_i,
  output logic      [W-1:0] level_o,
  output logic      [W-1:0] rise_o,
  output logic      [W-1:0] fall_o
);

  initial
  begin
    if (W < 1) $error("tev_edge_det: W must be at least 1");
  end

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] prev;
    logic [W-1:0] rise;
    logic [W-1:0] fall;
  } tev_edge_state_t;

  tev_edge_state_t st;
  tev_edge_state_t next_st;

  // ****************************************
  // two-stage sync and edge detection
  // ****************************************
  always_comb
  begin
    next_st      = st;
    next_st.meta = src_i;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
    next_st.rise = st.sync & ~st.prev;
    next_st.fall = ~st.sync & st.prev;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign level_o = st.prev;
  assign rise_o  = st.rise;
  assign fall_o  = st.fall;

endmodule : tev_edge_det

`default_nettype wire

// File: core/tev_irq_csr.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - all ports clocked by one sample clock
// - register accesses handled in sample clock domain
// - main reset active low, synchronously sampled
// - main reset clears buffers and control registers
// - enabled source edge, rising or falling, gives one-cycle irq
// - irq pulse synchronous with sample clock
// - status register shows live source levels
// - each occurrence latched in flag until cleared
// - writing one clears only those flags
// - enabled sources ORed onto irq
// - flags set regardless of enables
// - no new pulse without fresh edge
// - flag sets on status zero-to-one, stays set
// - event bits 0,1,2 rising; 4,5,6 falling
// - flag register at 0x28, zero after reset
module tev_irq_csr #(
  parameter int ADDR_W = tev_pkg::ADDR_W
) (
  input  wire logic              ref_clk_i,
  input  wire logic              rst_i,
  input  wire logic              main_rst_n_i,
  input  wire logic              gate_i,
  input  wire logic              sync_i,
  input  wire logic              second_pulse_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  output logic                   irq_o,
  output logic                   irq_level_o,
  output logic      [7:0]        ctrl_o
);

  initial
  begin
    if (ADDR_W < 6) $error("tev_irq_csr: ADDR_W must be at least 6");
    if (tev_pkg::EV_W != 7) $error("tev_irq_csr: event field must be 7 bits");
    if (tev_pkg::SRC_W != 3) $error("tev_irq_csr: three event sources expected");
    if (tev_pkg::BIT_GATE_FALL != tev_pkg::FALL_BASE)
    begin
      $error("tev_irq_csr: falling events must start at the fall base");
    end
    if (tev_pkg::BIT_SEC_RISE - tev_pkg::BIT_GATE_RISE + 1 != tev_pkg::SRC_W)
    begin
      $error("tev_irq_csr: rising event field width mismatch");
    end
    if (tev_pkg::BIT_SEC_FALL - tev_pkg::BIT_GATE_FALL + 1 != tev_pkg::SRC_W)
    begin
      $error("tev_irq_csr: falling event field width mismatch");
    end
    if (tev_pkg::DATA_W != 32) $error("tev_irq_csr: bus data must be 32 bits");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    tev_pkg::tev_bus_state_t bus;
    logic [31:0]             rdata;
    logic                    wait_req;
    logic                    rst_meta;
    logic                    rst_sync;
    logic [7:0]              ctrl;
    logic [6:0]              enable;
    logic [6:0]              flag;
    logic [6:0]              pending;
    logic [6:0]              mask;
    logic                    irq;
    logic                    irq_level;
  } tev_csr_state_t;

  tev_csr_state_t st;
  tev_csr_state_t next_st;

  logic [2:0] src_level;
  logic [2:0] src_rise;
  logic [2:0] src_fall;
  logic [6:0] events;
  logic [6:0] status_live;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [6:0] tev_pack(input logic [2:0] lo, input logic [2:0] hi);
    logic [6:0] v;
    v                                              = '0;
    v[tev_pkg::BIT_SEC_RISE:tev_pkg::BIT_GATE_RISE] = lo;
    v[tev_pkg::BIT_SEC_FALL:tev_pkg::BIT_GATE_FALL] = hi;
    return v;
  endfunction : tev_pack

  function automatic logic [31:0] tev_bemask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : tev_bemask

  // ****************************************
  // source edge detection
  // ****************************************
  tev_edge_det #(
    .W (tev_pkg::SRC_W)
  ) u_edge (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .src_i     ({second_pulse_i, sync_i, gate_i}),
    .level_o   (src_level),
    .rise_o    (src_rise),
    .fall_o    (src_fall)
  );

  assign events      = tev_pack(src_rise, src_fall);
  assign status_live = tev_pack(src_level, ~src_level);

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic [31:0] wmask;
    logic [6:0]  wr_bits;
    logic        do_wr;
    logic        do_rd;
    logic        soft_clr;
    logic        addr_hi;
    wmask    = tev_bemask(avs_byteenable_i);
    addr_hi  = |(avs_address_i >> 6);
    wr_bits  = avs_writedata_i[tev_pkg::EV_W-1:0] & wmask[tev_pkg::EV_W-1:0];
    do_wr    = avs_write_i && !st.wait_req;
    do_rd    = avs_read_i && !st.wait_req;
    next_st  = st;

    next_st.rst_meta = main_rst_n_i;
    next_st.rst_sync = st.rst_meta;
    soft_clr         = !st.rst_sync;

    // bus slave: one wait cycle, then answer
    case (st.bus)
      tev_pkg::TEV_BUS_IDLE:
      begin
        next_st.wait_req = 1'b1;
        if (avs_read_i || avs_write_i)
        begin
          next_st.bus      = tev_pkg::TEV_BUS_ACK;
          next_st.wait_req = 1'b0;
          next_st.rdata    = tev_pkg::READ_UNMAPPED;
          case (avs_address_i[5:0])
            tev_pkg::OFF_CTRL:    next_st.rdata = {24'h000000, st.ctrl};
            tev_pkg::OFF_STATUS:  next_st.rdata = {25'h0000000, status_live};
            tev_pkg::OFF_ENABLE:  next_st.rdata = {25'h0000000, st.enable};
            tev_pkg::OFF_FLAG:    next_st.rdata = {25'h0000000, st.flag};
            tev_pkg::OFF_PENDING: next_st.rdata = {25'h0000000, st.pending};
            tev_pkg::OFF_MASK:    next_st.rdata = {25'h0000000, st.mask};
            default:              next_st.rdata = tev_pkg::READ_UNMAPPED;
          endcase
          if (addr_hi)
          begin
            next_st.rdata = tev_pkg::READ_UNMAPPED;
          end
        end
      end
      tev_pkg::TEV_BUS_ACK:
      begin
        next_st.bus      = tev_pkg::TEV_BUS_IDLE;
        next_st.wait_req = 1'b1;
      end
      default:
      begin
        next_st.bus      = tev_pkg::TEV_BUS_IDLE;
        next_st.wait_req = 1'b1;
      end
    endcase

    // register writes and read side effects
    if (do_wr && !addr_hi)
    begin
      case (avs_address_i[5:0])
        tev_pkg::OFF_CTRL:
          next_st.ctrl = (st.ctrl & ~wmask[7:0]) | (avs_writedata_i[7:0] & wmask[7:0]);
        tev_pkg::OFF_ENABLE:
          next_st.enable = ((st.enable & ~wmask[6:0]) | wr_bits) & tev_pkg::EV_VALID;
        tev_pkg::OFF_FLAG:
          next_st.flag = st.flag & ~wr_bits;
        tev_pkg::OFF_MASK:
          next_st.mask = ((st.mask & ~wmask[6:0]) | wr_bits) & tev_pkg::EV_VALID;
        default:
          next_st.ctrl = st.ctrl;
      endcase
    end
    if (do_rd && avs_address_i == ADDR_W'(tev_pkg::OFF_PENDING))
    begin
      next_st.pending = '0;
    end

    // event capture, set wins over clear
    next_st.flag    = next_st.flag | events;
    next_st.pending = next_st.pending | events;

    // events are single-cycle, so the OR is one pulse per enabled edge, or one per group of enabled edges in the same cycle
    next_st.irq       = |(events & st.enable);
    next_st.irq_level = |(next_st.pending & st.mask);

    if (soft_clr)
    begin
      next_st.ctrl      = tev_pkg::CTRL_RESET;
      next_st.enable    = tev_pkg::EV_RESET;
      next_st.flag      = tev_pkg::EV_RESET;
      next_st.pending   = tev_pkg::EV_RESET;
      next_st.mask      = tev_pkg::EV_RESET;
      next_st.irq       = 1'b0;
      next_st.irq_level = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st          <= '0;
      st.bus      <= tev_pkg::TEV_BUS_IDLE;
      st.wait_req <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign avs_readdata_o    = st.rdata;
  assign avs_waitrequest_o = st.wait_req;
  assign irq_o             = st.irq;
  assign irq_level_o       = st.irq_level;
  assign ctrl_o            = st.ctrl;

endmodule : tev_irq_csr

`default_nettype wire

// File: dv/tev_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// host processor on the register bus
// ****************************************
module tev_host_model (
  input  wire logic        clk_i,
  input  wire logic        waitreq_i,
  input  wire logic [31:0] rdata_i,
  output logic      [5:0]  addr_o,
  output logic             rd_o,
  output logic             wr_o,
  output logic      [31:0] wdata_o,
  output logic      [3:0]  be_o
);
  initial
  begin
    {addr_o, rd_o, wr_o, wdata_o, be_o} = '0;
  end
  // write of ones clears flags, callers keep the service order
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    be_o    <= 4'hF;
    wr_o    <= 1'b1;
    do @(posedge clk_i); while (waitreq_i !== 1'b0);
    wr_o <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    do @(posedge clk_i); while (waitreq_i !== 1'b0);
    d    = rdata_i;
    rd_o <= 1'b0;
  endtask : rd
endmodule : tev_host_model
`default_nettype wire

// File: dv/tev_irq_csr_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module tev_chk (
  input wire logic        ref_clk_i,
  input wire logic        rst_i,
  input wire logic        main_rst_n_i,
  input wire logic        gate_i,
  input wire logic        sync_i,
  input wire logic        second_pulse_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        irq_o,
  input wire logic        irq_level_o,
  input wire logic [7:0]  ctrl_o
);
  logic [3:0] quiet;
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i) quiet <= 4'h0;
    else if (!($stable(gate_i) && $stable(sync_i) && $stable(second_pulse_i))) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  chk_irq_single: assert property (irq_o |=> !irq_o)
    else $error("irq longer than one cycle");
  chk_irq_fresh: assert property (quiet >= 4'h6 |-> !irq_o)
    else $error("irq without source edge");
  chk_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("no answer after one wait cycle");
  chk_wait_short: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer longer than one cycle");
  chk_idle_wait: assert property (!(avs_read_i || avs_write_i) && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer without request");
  chk_main_clear: assert property (!main_rst_n_i [*4] |-> ctrl_o == 8'h00 && !irq_o && !irq_level_o)
    else $error("main reset left state");
  chk_rsvd_zero: assert property (!avs_waitrequest_o && avs_read_i |-> avs_readdata_o[31:7] == 25'h0 && !avs_readdata_o[3])
    else $error("reserved bits read nonzero");
  chk_ctrl_write: assert property (!avs_waitrequest_o && avs_write_i && avs_address_i == tev_pkg::OFF_CTRL && main_rst_n_i && $past(main_rst_n_i, 3) |=> ctrl_o == $past(avs_writedata_i[7:0]))
    else $error("control write lost");
  cover property (irq_o);
  cover property (irq_level_o);
  cover property (!avs_waitrequest_o && avs_read_i);
endmodule : tev_chk
bind tev_irq_csr tev_chk u_chk (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .main_rst_n_i(main_rst_n_i),
  .gate_i(gate_i), .sync_i(sync_i), .second_pulse_i(second_pulse_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
  .irq_level_o(irq_level_o), .ctrl_o(ctrl_o));
`default_nettype wire

// File: dv/tev_irq_csr_test.sv
`timescale 1ns/1ps
`default_nettype none
module tev_irq_csr_test;
  logic        clk = 0, rst = 1, mrst_n = 1, g = 0, s = 0, p = 0;
  logic [5:0]  addr;
  logic        rd, wr, wreq, irq, lvl;
  logic [31:0] wdata, rdata;
  logic [3:0]  be;
  logic [7:0]  ctrl;
  int          n_errors = 0, samples_checked = 0, n_irq = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (irq === 1'b1) n_irq++;
  tev_irq_csr uut (.ref_clk_i(clk), .rst_i(rst), .main_rst_n_i(mrst_n), .gate_i(g), .sync_i(s),
    .second_pulse_i(p), .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wreq), .irq_o(irq), .irq_level_o(lvl), .ctrl_o(ctrl));
  tev_host_model host (.clk_i(clk), .waitreq_i(wreq), .rdata_i(rdata), .addr_o(addr), .rd_o(rd),
    .wr_o(wr), .wdata_o(wdata), .be_o(be));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rdchk(input string nm, input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] v;
    host.rd(a, v);
    chk(nm, v, exp);
  endtask : rdchk
  task automatic srcs(input logic [2:0] v);
    @(posedge clk);
    {p, s, g} <= v;
    repeat (10) @(posedge clk);
  endtask : srcs
  task automatic t_defaults;
    logic [5:0] offs [6] = '{tev_pkg::OFF_CTRL, tev_pkg::OFF_STATUS, tev_pkg::OFF_ENABLE,
      tev_pkg::OFF_FLAG, tev_pkg::OFF_PENDING, tev_pkg::OFF_MASK};
    logic [31:0] exps [6] = '{32'h0, 32'h70, 32'h0, 32'h0, 32'h0, 32'h0};
    foreach (offs[i]) rdchk("reset value", offs[i], exps[i]);
  endtask : t_defaults
  task automatic t_flags;
    srcs(3'h7);
    srcs(3'h0);
    rdchk("flag all", tev_pkg::OFF_FLAG, {25'h0, tev_pkg::EV_VALID});
    chk("irq disabled", n_irq, 0);
    host.wr(tev_pkg::OFF_FLAG, 32'h05);
    rdchk("flag part clear", tev_pkg::OFF_FLAG, 32'h72);
    host.wr(tev_pkg::OFF_FLAG, 32'hFF);
    rdchk("flag cleared", tev_pkg::OFF_FLAG, 32'h0);
  endtask : t_flags
  task automatic t_irq;
    int n0;
    host.wr(tev_pkg::OFF_ENABLE, 32'h77);
    n0 = n_irq;
    srcs(3'h7);
    chk("one pulse", n_irq, n0 + 1);
    rdchk("status high", tev_pkg::OFF_STATUS, 32'h07);
    repeat (20) @(posedge clk);
    chk("no repeat", n_irq, n0 + 1);
    srcs(3'h2);
    chk("fall pulse", n_irq, n0 + 2);
    rdchk("status mixed", tev_pkg::OFF_STATUS, 32'h52);
  endtask : t_irq
  task automatic t_level;
    logic [31:0] v;
    host.wr(tev_pkg::OFF_MASK, 32'h01);
    repeat (3) @(posedge clk);
    chk("level on", lvl, 1'b1);
    host.rd(tev_pkg::OFF_PENDING, v);
    repeat (3) @(posedge clk);
    chk("level off", lvl, 1'b0);
  endtask : t_level
  task automatic t_main;
    host.wr(tev_pkg::OFF_CTRL, 32'hA5);
    @(posedge clk);
    chk("ctrl", ctrl, 8'hA5);
    mrst_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk("ctrl cleared", ctrl, 8'h00);
    mrst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rdchk("enable cleared", tev_pkg::OFF_ENABLE, 32'h0);
    host.wr(6'h10, 32'hFFFF_FFFF);
    rdchk("unmapped", 6'h10, 32'h0);
  endtask : t_main
  task automatic end_of_test;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_defaults();
    t_flags();
    t_irq();
    t_level();
    t_main();
    end_of_test();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule : tev_irq_csr_test
`default_nettype wire
